// file: logic/ubd_cycle_qual.sv
`timescale 1ns/1ps
module ubd_cycle_qual
   import ubd_pkg::*;
(
   // Configuration
   input  wire ubd_cond_type  cond,
   // Observed cycle
   input  wire ubd_cycle_type cycle,
   // Result
   output logic               cycle_hit
);
   logic bus_ok;
   logic size_ok;

   always_comb begin
      if (!cond.xy_enable)
         bus_ok = cycle.bus == BUS_INTERNAL;
      else
         bus_ok = cycle.bus == (cond.xy_side ? BUS_Y : BUS_X);
      size_ok = cond.size_sel == SIZE_ANY || cond.size_sel == cycle.size;
      cycle_hit = cycle.valid && bus_ok && size_ok
                  && sel_hit(cond.source_sel, cycle.is_dma)
                  && sel_hit(cond.fetch_sel, !cycle.is_fetch)
                  && sel_hit(cond.dir_sel, cycle.is_write);
   end
endmodule

// file: logic/ubd_data_cmp.sv
`timescale 1ns/1ps
module ubd_data_cmp
   import ubd_pkg::*;
(
   // Configuration
   input  wire ubd_cond_type cond,
   input  wire logic [31:0]  compare_value,
   input  wire logic [31:0]  mask,
   // Observed cycle
   input  wire ubd_cycle_type cycle,
   // Result
   output logic              data_hit
);
   logic [31:0] cmp_v;
   logic [31:0] msk_v;
   logic [31:0] bus_v;

   always_comb begin
      cmp_v = compare_value;
      msk_v = mask;
      bus_v = cycle.data;
      if (cond.xy_enable) begin
         bus_v = {16'h0000, cycle.data[15:0]};
         if (!cond.xy_side) begin
            cmp_v = {16'h0000, compare_value[31:16]};
            msk_v = {16'hffff, mask[31:16]};
         end else begin
            cmp_v = {16'h0000, compare_value[15:0]};
            msk_v = {16'hffff, mask[15:0]};
         end
      end else if (cond.size_sel == SIZE_BYTE) begin
         // Byte arrives on data[7:0]; lane picked by address parity
         bus_v = {24'h000000, cycle.data[7:0]};
         if (cycle.addr_odd) begin
            cmp_v = {24'h000000, compare_value[7:0]};
            msk_v = {24'hffffff, mask[7:0]};
         end else begin
            cmp_v = {24'h000000, compare_value[15:8]};
            msk_v = {24'hffffff, mask[15:8]};
         end
      end else if (cond.size_sel == SIZE_WORD) begin
         bus_v = {16'h0000, cycle.data[15:0]};
         cmp_v = {16'h0000, compare_value[15:0]};
         msk_v = {16'hffff, mask[15:0]};
      end
      data_hit = ((bus_v ^ cmp_v) & ~msk_v) == 32'h00000000;
   end
endmodule

// file: logic/ubd_pkg.sv
package ubd_pkg;
   localparam logic [7:0]  OFS_MASK_HIGH = 8'h00;
   localparam logic [7:0]  OFS_MASK_LOW  = 8'h04;
   localparam logic [7:0]  OFS_CMP_HIGH  = 8'h08;
   localparam logic [7:0]  OFS_CMP_LOW   = 8'h0c;
   localparam logic [7:0]  OFS_BUS_COND  = 8'h10;
   localparam logic [7:0]  OFS_COUNT     = 8'h14;
   localparam logic [7:0]  OFS_CONTROL   = 8'h18;
   localparam logic [15:0] RESET_VALUE   = 16'h0000;
   localparam logic [15:0] COND_WMASK    = 16'h03ff;
   localparam logic [15:0] CTRL_WMASK    = 16'h00ec;
   localparam int          XY_ENABLE_BIT = 9;
   localparam int          XY_SIDE_BIT   = 8;
   localparam int          FLAG_CPU_BIT  = 7;
   localparam int          FLAG_DMA_BIT  = 6;
   localparam int          COUNT_EN_BIT  = 5;
   localparam int          DATA_EN_BIT   = 3;
   localparam int          COUNT_WIDTH   = 12;
   localparam logic [1:0]  SEL_NONE      = 2'h0;
   localparam logic [1:0]  SEL_FIRST     = 2'h1;
   localparam logic [1:0]  SEL_SECOND    = 2'h2;
   localparam logic [1:0]  SIZE_ANY      = 2'h0;
   localparam logic [1:0]  SIZE_BYTE     = 2'h1;
   localparam logic [1:0]  SIZE_WORD     = 2'h2;
   localparam logic [1:0]  SIZE_LONG     = 2'h3;

   typedef enum logic [1:0] {
      BUS_INTERNAL = 2'h0,
      BUS_X        = 2'h1,
      BUS_Y        = 2'h2
   } ubd_bus_type;

   // One observed bus cycle; X/Y data sits in data[15:0]
   typedef struct packed {
      logic        valid;
      ubd_bus_type bus;
      logic        is_dma;
      logic        is_fetch;
      logic        is_write;
      logic [1:0]  size;
      logic        addr_odd;
      logic        short_loop;
      logic [31:0] data;
   } ubd_cycle_type;

   typedef struct packed {
      logic       xy_enable;
      logic       xy_side;
      logic [1:0] source_sel;
      logic [1:0] fetch_sel;
      logic [1:0] dir_sel;
      logic [1:0] size_sel;
   } ubd_cond_type;

   // 2-bit selector: 01 first choice, 10 second, 11 either, 00 never
   function automatic logic sel_hit(input logic [1:0] sel,
                                    input logic       second);
      return second ? sel[1] : sel[0];
   endfunction
endpackage

// file: logic/ubd_top.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module ubd_top
   import ubd_pkg::*;
#(
   parameter int CNT_W = COUNT_WIDTH
)(
   // Clock and power-on reset
   input  wire logic          CLK,
   input  wire logic          ARST_N,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [7:0]    PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic [31:0]        PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   // Observed bus cycle
   input  wire ubd_cycle_type CYCLE,
   // Break request
   output logic               BREAK_REQ
);
   initial begin
      if (CNT_W < 1 || CNT_W > 16)
         $error("CNT_W must be 1 to 16");
   end

   logic [15:0]      data_mask_high;
   logic [15:0]      data_mask_low;
   logic [15:0]      compare_data_high;
   logic [15:0]      compare_data_low;
   logic [15:0]      bus_cycle_condition;
   logic [CNT_W-1:0] match_count;
   logic [7:0]       break_control;
   ubd_cond_type     cond;
   logic             data_hit;
   logic             cycle_hit;
   logic             match;
   logic             count_on;
   logic             fire;
   logic             wr_en;
   logic             rd_en;
   logic             mapped;
   logic [31:0]      rd_value;

   function automatic logic [15:0] wmerge(input logic [15:0] wmask,
                                          input logic [31:0] wdata);
      return wdata[15:0] & wmask;
   endfunction

   assign cond = bus_cycle_condition[9:0];

   ubd_data_cmp u_data_cmp (
      .cond          (cond),
      .compare_value ({compare_data_high, compare_data_low}),
      .mask          ({data_mask_high, data_mask_low}),
      .cycle         (CYCLE),
      .data_hit      (data_hit)
   );

   ubd_cycle_qual u_cycle_qual (
      .cond      (cond),
      .cycle     (CYCLE),
      .cycle_hit (cycle_hit)
   );

   // Data compare only counts when enabled in control
   assign match = cycle_hit
                  && (!break_control[DATA_EN_BIT] || data_hit);
   assign count_on = break_control[COUNT_EN_BIT];
   // Exceptions cannot land in a short loop, so in count mode no break there either
   assign fire = match && (!count_on
                 || (!CYCLE.short_loop
                     && match_count <= CNT_W'(1)));

   // Zero-wait slave; writes land at the access edge
   assign PREADY = 1'b1;
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_en = PSEL && !PENABLE && !PWRITE;

   always_comb begin
      mapped = 1'b1;
      rd_value = 32'h00000000;
      unique case (PADDR)
         OFS_MASK_HIGH: rd_value[15:0] = data_mask_high;
         OFS_MASK_LOW:  rd_value[15:0] = data_mask_low;
         OFS_CMP_HIGH:  rd_value[15:0] = compare_data_high;
         OFS_CMP_LOW:   rd_value[15:0] = compare_data_low;
         OFS_BUS_COND:  rd_value[15:0] = bus_cycle_condition;
         OFS_COUNT:     rd_value[CNT_W-1:0] = match_count;
         OFS_CONTROL:   rd_value[7:0] = break_control;
         default:       mapped = 1'b0;
      endcase
   end

   assign PSLVERR = PSEL && PENABLE && !mapped;

   // Read data captured in setup, stable through access
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         PRDATA <= 32'h00000000;
      else if (rd_en)
         PRDATA <= rd_value;
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         data_mask_high <= RESET_VALUE;
         data_mask_low  <= RESET_VALUE;
      end else if (wr_en && PADDR == OFS_MASK_HIGH) begin
         data_mask_high <= PWDATA[15:0];
      end else if (wr_en && PADDR == OFS_MASK_LOW) begin
         data_mask_low <= PWDATA[15:0];
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         compare_data_high <= RESET_VALUE;
         compare_data_low  <= RESET_VALUE;
      end else if (wr_en && PADDR == OFS_CMP_HIGH) begin
         compare_data_high <= PWDATA[15:0];
      end else if (wr_en && PADDR == OFS_CMP_LOW) begin
         compare_data_low <= PWDATA[15:0];
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         bus_cycle_condition <= RESET_VALUE;
      else if (wr_en && PADDR == OFS_BUS_COND)
         bus_cycle_condition <= wmerge(COND_WMASK, PWDATA);
   end

   // A hardware decrement wins over a software write in one cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         match_count <= '0;
      else if (match && count_on && !CYCLE.short_loop) begin
         if (match_count != '0)
            match_count <= match_count - CNT_W'(1);
      end else if (wr_en && PADDR == OFS_COUNT) begin
         match_count <= PWDATA[CNT_W-1:0];
      end
   end

   // Sticky flags: write 0 clears, a new break (fire) wins over the clear
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         break_control <= 8'h00;
      end else begin
         if (wr_en && PADDR == OFS_CONTROL)
            break_control <= PWDATA[7:0] & ((CTRL_WMASK[7:0] & 8'h3f)
                             | (break_control & 8'hc0));
         if (fire && !CYCLE.is_dma)
            break_control[FLAG_CPU_BIT] <= 1'b1;
         if (fire && CYCLE.is_dma)
            break_control[FLAG_DMA_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         BREAK_REQ <= 1'b0;
      else
         BREAK_REQ <= fire;
   end

   property p_direct_break;
      @(posedge CLK) disable iff (!ARST_N)
      match && !count_on |=> BREAK_REQ;
   endproperty
   a_direct_break: assert property (p_direct_break)
      else $error("match without count mode gave no break");

   property p_count_hold_off;
      @(posedge CLK) disable iff (!ARST_N)
      !count_on && !wr_en |=> $stable(match_count);
   endproperty
   a_count_hold_off: assert property (p_count_hold_off)
      else $error("count changed with count mode off");

   property p_decrement;
      @(posedge CLK) disable iff (!ARST_N)
      match && count_on && !CYCLE.short_loop && match_count > CNT_W'(1)
      |=> match_count == $past(match_count) - CNT_W'(1) && !BREAK_REQ;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("count did not fall by one");

   property p_break_at_one;
      @(posedge CLK) disable iff (!ARST_N)
      match && count_on && !CYCLE.short_loop && match_count == CNT_W'(1)
      |=> BREAK_REQ && match_count == '0;
   endproperty
   a_break_at_one: assert property (p_break_at_one)
      else $error("no break when count at one");

   property p_short_loop;
      @(posedge CLK) disable iff (!ARST_N)
      match && count_on && CYCLE.short_loop
      && !(wr_en && PADDR == OFS_COUNT)
      |=> $stable(match_count) && !BREAK_REQ;
   endproperty
   a_short_loop: assert property (p_short_loop)
      else $error("short loop match changed count");

   property p_cond_reserved;
      @(posedge CLK) disable iff (!ARST_N)
      bus_cycle_condition[15:10] == 6'h00;
   endproperty
   a_cond_reserved: assert property (p_cond_reserved)
      else $error("reserved condition bits set");

   property p_count_read_top;
      @(posedge CLK) disable iff (!ARST_N)
      PSEL && PENABLE && PADDR == OFS_COUNT && !PWRITE
      |-> PRDATA[31:CNT_W] == '0;
   endproperty
   a_count_read_top: assert property (p_count_read_top)
      else $error("count upper bits read nonzero");

   property p_mask_write;
      @(posedge CLK) disable iff (!ARST_N)
      wr_en && PADDR == OFS_MASK_LOW
      |=> data_mask_low == $past(PWDATA[15:0]);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("low mask not written");

   property p_wrong_bus;
      @(posedge CLK) disable iff (!ARST_N)
      CYCLE.valid && !cond.xy_enable && CYCLE.bus != BUS_INTERNAL
      |-> !match;
   endproperty
   a_wrong_bus: assert property (p_wrong_bus)
      else $error("match on unselected bus");

   property p_full_mask;
      @(posedge CLK) disable iff (!ARST_N)
      cycle_hit && {data_mask_high, data_mask_low} == 32'hffffffff
      |-> match;
   endproperty
   a_full_mask: assert property (p_full_mask)
      else $error("fully masked data blocked match");

   property p_flag_sticky;
      @(posedge CLK) disable iff (!ARST_N)
      break_control[FLAG_CPU_BIT] && !wr_en
      |=> break_control[FLAG_CPU_BIT];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("match flag dropped by itself");

   property p_count_write;
      @(posedge CLK) disable iff (!ARST_N)
      wr_en && PADDR == OFS_COUNT && !(match && count_on && !CYCLE.short_loop)
      |=> match_count == $past(PWDATA[CNT_W-1:0]);
   endproperty
   a_count_write: assert property (p_count_write)
      else $error("count write did not land");

   property p_cond_write;
      @(posedge CLK) disable iff (!ARST_N)
      wr_en && PADDR == OFS_BUS_COND
      |=> bus_cycle_condition[9:0] == $past(PWDATA[9:0]);
   endproperty
   a_cond_write: assert property (p_cond_write)
      else $error("condition write did not land");

   property p_xy_other_bus;
      @(posedge CLK) disable iff (!ARST_N)
      cond.xy_enable && CYCLE.bus == (cond.xy_side ? BUS_X : BUS_Y)
      |-> !cycle_hit;
   endproperty
   a_xy_other_bus: assert property (p_xy_other_bus)
      else $error("hit on unselected X/Y bus");

   property p_x_exact;
      @(posedge CLK) disable iff (!ARST_N)
      cond.xy_enable && !cond.xy_side
      && CYCLE.data[15:0] == compare_data_high
      |-> data_hit;
   endproperty
   a_x_exact: assert property (p_x_exact)
      else $error("X data equal to high compare missed");

   property p_x_mask;
      @(posedge CLK) disable iff (!ARST_N)
      cond.xy_enable && !cond.xy_side && data_mask_high == 16'hffff
      |-> data_hit;
   endproperty
   a_x_mask: assert property (p_x_mask)
      else $error("X compare used low mask half");

   property p_y_mask;
      @(posedge CLK) disable iff (!ARST_N)
      cond.xy_enable && cond.xy_side && data_mask_low == 16'hffff
      |-> data_hit;
   endproperty
   a_y_mask: assert property (p_y_mask)
      else $error("Y compare used high mask half");

   property p_byte_odd;
      @(posedge CLK) disable iff (!ARST_N)
      !cond.xy_enable && cond.size_sel == SIZE_BYTE && CYCLE.addr_odd
      && CYCLE.data[7:0] == compare_data_low[7:0]
      |-> data_hit;
   endproperty
   a_byte_odd: assert property (p_byte_odd)
      else $error("odd byte lane missed");

   property p_byte_even;
      @(posedge CLK) disable iff (!ARST_N)
      !cond.xy_enable && cond.size_sel == SIZE_BYTE && !CYCLE.addr_odd
      && CYCLE.data[7:0] == compare_data_low[15:8]
      |-> data_hit;
   endproperty
   a_byte_even: assert property (p_byte_even)
      else $error("even byte lane missed");

   property p_exact_miss;
      @(posedge CLK) disable iff (!ARST_N)
      !cond.xy_enable && cond.size_sel != SIZE_BYTE
      && cond.size_sel != SIZE_WORD
      && {data_mask_high, data_mask_low} == 32'h00000000
      && CYCLE.data != {compare_data_high, compare_data_low}
      |-> !data_hit;
   endproperty
   a_exact_miss: assert property (p_exact_miss)
      else $error("unmasked data difference still hit");

   property p_read_mask;
      @(posedge CLK) disable iff (!ARST_N)
      PSEL && PENABLE && !PWRITE && PADDR == OFS_MASK_HIGH
      |-> PRDATA == {16'h0000, data_mask_high};
   endproperty
   a_read_mask: assert property (p_read_mask)
      else $error("high mask read back wrong");

   c_direct: cover property (@(posedge CLK) disable iff (!ARST_N)
      match && !count_on ##1 BREAK_REQ);
   c_countdown: cover property (@(posedge CLK) disable iff (!ARST_N)
      match_count == CNT_W'(2) ##[1:20] BREAK_REQ && count_on);
   c_xy_y: cover property (@(posedge CLK) disable iff (!ARST_N)
      match && cond.xy_enable && cond.xy_side);
   c_byte_even: cover property (@(posedge CLK) disable iff (!ARST_N)
      match && cond.size_sel == SIZE_BYTE && !CYCLE.addr_odd);
   c_short_loop: cover property (@(posedge CLK) disable iff (!ARST_N)
      match && count_on && CYCLE.short_loop);
endmodule

// file: test/break_channel_d_match_counter_bench.sv
`timescale 1ns/1ps
module break_channel_d_match_counter_bench
   import ubd_pkg::*;
;
   logic          CLK, ARST_N, PSEL, PENABLE, PWRITE;
   logic [7:0]    PADDR;
   logic [31:0]   PWDATA, PRDATA, want;
   logic          PREADY, PSLVERR, BREAK_REQ, en, run;
   ubd_cycle_type CYCLE;
   logic [15:0]   sh [7];
   logic          brk = 1'b0;
   int            n_errors = 0;
   int            cmp_count = 0;

   ubd_top dut_u (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CYCLE(CYCLE),
      .BREAK_REQ(BREAK_REQ));
   ubd_cycle_src cyc_u (.CLK(CLK), .en(en), .want(want), .cyc(CYCLE));

   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s exp %h got %h", n, e, g);
         n_errors++;
      end
   endtask

   task automatic chk_brk(logic e, logic g);
      chk("break", 32'(e), 32'(g));
   endtask

   task automatic results;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic apb(bit w, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
         @(posedge CLK);
      while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(int i, logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, 8'(i * 4), d, rd, er);
      sh[i] = d[15:0] & (i == 4 ? COND_WMASK : i == 5 ? 16'h0fff :
                         i == 6 ? CTRL_WMASK : 16'hffff);
   endtask

   task automatic rdc(int i);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, 8'(i * 4), 32'h0, rd, er);
      chk("register", {16'h0, sh[i]}, rd);
   endtask

   function automatic bit sl(logic [1:0] s, logic b);
      return b ? s[1] : s[0];
   endfunction

   function automatic bit hit(ubd_cycle_type c);
      logic [15:0] q;
      logic [31:0] m, d;
      bit          ok;
      q = sh[4];
      m = ~{sh[0], sh[1]};
      d = c.data;
      ok = c.valid && sl(q[7:6], c.is_dma) && sl(q[5:4], !c.is_fetch) &&
           sl(q[3:2], c.is_write) && (q[1:0] == 2'h0 || q[1:0] == c.size);
      if (!q[XY_ENABLE_BIT])
         ok &= c.bus == BUS_INTERNAL;
      else
         ok &= c.bus == (q[XY_SIDE_BIT] ? BUS_Y : BUS_X);
      if (q[XY_ENABLE_BIT]) begin
         d = q[8] ? {16'h0, d[15:0]} : {d[15:0], 16'h0};
         m &= q[8] ? 32'h0000ffff : 32'hffff0000;
      end else if (q[1:0] == SIZE_BYTE) begin
         d = c.addr_odd ? {24'h0, d[7:0]} : {16'h0, d[7:0], 8'h0};
         m &= c.addr_odd ? 32'h000000ff : 32'h0000ff00;
      end else if (q[1:0] == SIZE_WORD) begin
         d = {16'h0, d[15:0]};
         m &= 32'h0000ffff;
      end
      if (sh[6][DATA_EN_BIT])
         ok &= ((d ^ {sh[2], sh[3]}) & m) == 0;
      return ok;
   endfunction

   always @(posedge CLK) begin
      brk = 1'b0;
      if (run && hit(CYCLE)) begin
         if (!sh[6][COUNT_EN_BIT])
            brk = 1'b1;
         else if (!CYCLE.short_loop) begin
            brk = sh[5] <= 16'h1;
            if (sh[5] != 16'h0)
               sh[5] = sh[5] - 16'h1;
         end
      end
      if (brk)
         sh[6][CYCLE.is_dma ? FLAG_DMA_BIT : FLAG_CPU_BIT] = 1'b1;
   end

   always @(negedge CLK)
      if (ARST_N)
         chk_brk(brk, BREAK_REQ);

   initial begin
      #500us;
      n_errors++;
      results();
   end

   initial begin
      logic [15:0] q;
      logic [31:0] rd;
      logic        er;
      bit          den, cen;
      void'($urandom(32'hde43));
      {ARST_N, PSEL, PENABLE, PWRITE, en, run} = 6'h0;
      PADDR = 8'h0;
      PWDATA = 32'h0;
      want = 32'h0;
      for (int i = 0; i < 7; i++)
         sh[i] = 16'h0;
      repeat (6) @(posedge CLK);
      ARST_N <= 1'b1;
      for (int i = 0; i < 7; i++)
         rdc(i);
      apb(1'b0, 8'h1c, 32'h0, rd, er);
      chk("unmapped", 32'h1, {rd[30:0], er});
      for (int i = 0; i < 6; i++) begin
         wr(i, 32'hffffffff);
         rdc(i);
      end
      repeat (60) begin
         for (int i = 0; i < 4; i++)
            wr(i, $urandom);
         den = 1'($urandom);
         cen = 1'($urandom);
         q = 16'h0;
         q[9:8] = 2'($urandom);
         for (int k = 2; k < 8; k += 2)
            q[k +: 2] = 2'(1 + $urandom % 3);
         q[1:0] = 2'($urandom);
         if (den)
            q[1:0] = 2'(1 + $urandom % 3);
         wr(4, {16'h0, q});
         wr(5, $urandom % 5);
         wr(6, 32'(den) << DATA_EN_BIT | 32'(cen) << COUNT_EN_BIT);
         want <= {sh[2], sh[3]};
         en <= 1'b1;
         run <= 1'b1;
         repeat (40) @(posedge CLK);
         en <= 1'b0;
         @(posedge CLK);
         run <= 1'b0;
         rdc(5);
         rdc(6);
      end
      results();
   end
endmodule

// file: test/ubd_cycle_src.sv
`timescale 1ns/1ps
module ubd_cycle_src
   import ubd_pkg::*;
(
   // Clock and control
   input  wire logic        CLK,
   input  wire logic        en,
   input  wire logic [31:0] want,
   // Bus cycle seen by the unit
   output ubd_cycle_type    cyc
);
   ubd_cycle_type c;
   logic [31:0]   r;
   initial cyc = '0;
   always @(posedge CLK) begin
      r = $urandom;
      c = '0;
      c.bus = ubd_bus_type'(r[1:0] % 3);
      c.is_dma = r[2];
      c.is_fetch = r[3];
      c.is_write = r[4];
      c.addr_odd = r[5];
      c.short_loop = r[7:6] == 2'h0;
      c.size = r[8] ? SIZE_LONG : r[18] ? SIZE_WORD : SIZE_BYTE;
      if (c.bus != BUS_INTERNAL)
         c.size = SIZE_WORD;
      c.data = $urandom;
      // Mostly aim at the compare value so matches occur
      if (c.bus == BUS_X)
         c.data[15:0] = want[31:16];
      else if (c.bus == BUS_Y)
         c.data[15:0] = want[15:0];
      else if (c.size == SIZE_LONG)
         c.data = want;
      else if (c.size == SIZE_WORD)
         c.data[15:0] = want[15:0];
      else
         c.data[7:0] = c.addr_odd ? want[7:0] : want[15:8];
      if (r[10:9] == 2'h0)
         c.data[r[15:11]] = ~c.data[r[15:11]];
      // Gaps give a slow source; idle data keeps toggling
      c.valid = en && r[17:16] != 2'h0;
      if (!c.valid)
         c.data = ~cyc.data;
      cyc <= c;
   end
endmodule
